// >>> hdl/erpg_pkg.sv
// Purpose: Shared constants and types of the event report packet generator
// Assumes: 16-bit packet words, 20 MHz core clock
// Notes: Packet is sixteen words, checksum last
package erpg_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCAN_STEP_US = 50;
	localparam int SCAN_STEP_CYC = (SCAN_STEP_US * 1000) / CLK_PERIOD_NS;
	localparam logic [10:0] APID = 11'h500;
	localparam logic [15:0] SID = 16'h0520;
	localparam logic [4:0] HDR_FLAGS = 5'h01;
	localparam logic [1:0] SEQ_FLAGS = 2'h3;
	localparam logic [15:0] PKT_LEN = 16'h0019;
	localparam logic [7:0] DFH_FLAGS = 8'h10;
	localparam logic [7:0] SVC_TYPE = 8'h05;
	localparam logic [7:0] SVC_SUBTYPE = 8'h02;
	localparam logic [7:0] DFH_SPARE = 8'h00;
	localparam int PKT_WORDS = 16;
	localparam logic [3:0] LAST_IDX = 4'hF;
	localparam logic [15:0] EV_RCU_FAULT = 16'hC000;
	localparam logic [15:0] EV_PU_FAULT = 16'hC010;
	localparam logic [15:0] EV_OBS_FAULT = 16'hC100;
	localparam logic [15:0] EV_OBS_FIXED = 16'hC110;
	localparam logic [8:0] TC_MAX_OCTETS = 9'h100;
	localparam logic [8:0] TC_CNT_SAT = 9'h101;
	localparam logic [7:0] OP_SAFE = 8'h5A;
	localparam logic [7:0] OP_RESUME = 8'h5B;
	localparam int OP_HAZ_BIT = 7;
	localparam logic [4:0] RT_ADDR_PRIME = 5'h01;
	localparam logic [4:0] RT_ADDR_REDUN = 5'h02;
	localparam logic [1:0] CAP_AT = 2'h2;
	typedef enum logic [0:0] {ERPG_IDLE = 1'b0, ERPG_SEND = 1'b1} erpg_tx_e;
endpackage

// >>> hdl/erpg_ev_if.sv
// Purpose: Event request carrier between arbiter and serializer
// Assumes: One request pulse while busy is low
// Notes: Fields hold steady from the request cycle until the next request
interface erpg_ev_if;
	logic req;
	logic busy;
	logic [15:0] ev_id;
	logic [31:0] obs_id;
	logic [31:0] bb_id;
	logic [47:0] ev_time;
	modport src (output req, ev_id, obs_id, bb_id, ev_time, input busy);
	modport snk (input req, ev_id, obs_id, bb_id, ev_time, output busy);
endinterface

// >>> hdl/erpg_ser.sv
// Purpose: Serializes one event report packet into 16-bit words
// Assumes: Downstream accepts a word on tx_valid and tx_ready
// Notes: Checksum is the 16-bit sum of the fifteen words before it
module erpg_ser (
	input wire logic core_clk,
	input wire logic rst,
	erpg_ev_if.snk ev,
	input wire logic tx_ready,
	output logic [15:0] tx_data,
	output logic tx_valid,
	output logic tx_last
);
	erpg_pkg::erpg_tx_e state_r;
	logic [3:0] idx_r;
	logic [15:0] csum_r;
	logic [13:0] src_cnt_r;
	logic [15:0] ev_seq_r;
	logic [15:0] id_r;
	logic [31:0] obs_r;
	logic [31:0] bb_r;
	logic [47:0] time_r;
	logic [15:0] tx_data_r;
	logic tx_valid_r;
	logic tx_last_r;
	logic [15:0] words [erpg_pkg::PKT_WORDS];
	wire logic start = (state_r == erpg_pkg::ERPG_IDLE) && ev.req;
	wire logic step = (state_r == erpg_pkg::ERPG_SEND) && tx_ready;
	wire logic done = step && tx_last_r;

	// Primary header, then type 5 subtype 2 data field header
	assign words[0] = {erpg_pkg::HDR_FLAGS, erpg_pkg::APID};
	assign words[1] = {erpg_pkg::SEQ_FLAGS, src_cnt_r};
	assign words[2] = erpg_pkg::PKT_LEN;
	assign words[3] = {erpg_pkg::DFH_FLAGS, erpg_pkg::SVC_TYPE};
	assign words[4] = {erpg_pkg::SVC_SUBTYPE, erpg_pkg::DFH_SPARE};
	assign words[5] = time_r[47:32];
	assign words[6] = time_r[31:16];
	assign words[7] = time_r[15:0];
	assign words[8] = id_r;
	assign words[9] = erpg_pkg::SID;
	assign words[10] = obs_r[31:16];
	assign words[11] = obs_r[15:0];
	assign words[12] = bb_r[31:16];
	assign words[13] = bb_r[15:0];
	// No second parameter area follows the block id
	assign words[14] = ev_seq_r;
	assign words[15] = csum_r;

	assign ev.busy = (state_r != erpg_pkg::ERPG_IDLE);
	assign tx_data = tx_data_r;
	assign tx_valid = tx_valid_r;
	assign tx_last = tx_last_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= erpg_pkg::ERPG_IDLE;
			idx_r <= 4'h0;
			csum_r <= 16'h0000;
			src_cnt_r <= 14'h0000;
			ev_seq_r <= 16'h0000;
			id_r <= 16'h0000;
			obs_r <= 32'h0000_0000;
			bb_r <= 32'h0000_0000;
			time_r <= 48'h0000_0000_0000;
			tx_data_r <= 16'h0000;
			tx_valid_r <= 1'b0;
			tx_last_r <= 1'b0;
		end else begin
			case (state_r)
				erpg_pkg::ERPG_IDLE: begin
					if (start) begin
						id_r <= ev.ev_id;
						obs_r <= ev.obs_id;
						bb_r <= ev.bb_id;
						time_r <= ev.ev_time;
						tx_data_r <= words[0];
						csum_r <= words[0];
						idx_r <= 4'h1;
						tx_valid_r <= 1'b1;
						state_r <= erpg_pkg::ERPG_SEND;
					end
				end
				erpg_pkg::ERPG_SEND: begin
					if (done) begin
						tx_valid_r <= 1'b0;
						tx_last_r <= 1'b0;
						src_cnt_r <= src_cnt_r + 14'h0001;
						ev_seq_r <= ev_seq_r + 16'h0001;
						state_r <= erpg_pkg::ERPG_IDLE;
					end else if (step) begin
						tx_data_r <= words[idx_r];
						csum_r <= csum_r + words[idx_r];
						tx_last_r <= (idx_r == erpg_pkg::LAST_IDX);
						idx_r <= idx_r + 4'h1;
					end
				end
				default: state_r <= erpg_pkg::ERPG_IDLE;
			endcase
		end
	end

	// Handshake count inside the current packet
	logic [4:0] hs_cnt_r;
	always_ff @(posedge core_clk) begin
		if (rst || start) begin
			hs_cnt_r <= 5'h00;
		end else if (step) begin
			hs_cnt_r <= hs_cnt_r + 5'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_first_word_apid: assert property ($rose(tx_valid_r) |-> tx_data_r == 16'h0D00)
		else $error("first packet word does not carry the application id");
	a_packet_length: assert property (done |-> hs_cnt_r == 5'h0F)
		else $error("packet is not sixteen words long");
	a_obs_id_word: assert property (tx_valid_r && idx_r == 4'hB |-> tx_data_r == obs_r[31:16])
		else $error("observation id missing from parameter area");
	a_seq_counter: assert property (done |=> ev_seq_r == $past(ev_seq_r) + 16'h0001)
		else $error("event sequence counter did not advance");
	c_packet_sent: cover property (done);
endmodule // erpg_ser

// >>> hdl/erpg_top.sv
// Purpose: Event report packets, telecommand screening, safe mode, ROM check
// Assumes: Fault, upset and strap pins are asynchronous; the rest is core_clk logic
// Notes: ROM data follows rom_addr with a step period of settling time
// Operation
// - Events sent as type 5/2, fixed APID, SID
// - First parameters: observation id, then block id
// - Second parameter area left out
// - Readout unit fault sends event C000
// - Processing unit fault sends event C010
// - Observation problem sends event C100
// - Observation fix sends event C110
// - Telecommands over 256 octets are refused
// - One command alone enters safe mode
// - Prime and redundant units use distinct addresses
// - Hazardous commands are refused in safe mode
// - Background ROM checksum, inhibitable upset safing
module erpg_top #(
	parameter int ROM_AW = 10,
	parameter logic [15:0] ROM_SUM_REF = 16'h0000
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rcu_fault_pin,
	input wire logic pu_fault_pin,
	input wire logic seu_pin,
	input wire logic redundant_strap,
	input wire logic obs_anomaly,
	input wire logic obs_corrected,
	input wire logic seu_safing_inhibit,
	input wire logic [31:0] obs_id,
	input wire logic [31:0] bb_id,
	input wire logic [47:0] obs_time,
	input wire logic tc_valid,
	input wire logic tc_first,
	input wire logic tc_last,
	input wire logic [7:0] tc_data,
	input wire logic [15:0] rom_data,
	input wire logic tx_ready,
	output logic [15:0] tx_data,
	output logic tx_valid,
	output logic tx_last,
	output logic tc_accept,
	output logic tc_reject,
	output logic safe_mode,
	output logic [4:0] rt_addr,
	output logic [ROM_AW-1:0] rom_addr,
	output logic rom_err
);
	localparam logic [ROM_AW-1:0] ROM_LAST = '1;
	localparam logic [15:0] STEP_LAST = 16'(erpg_pkg::SCAN_STEP_CYC - 1);

	// Pin synchronisers: strap, upset, unit fault, readout fault
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic [2:0] sync_d_r;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_r <= 4'h0;
			sync_r <= 4'h0;
			sync_d_r <= 3'h0;
		end else begin
			meta_r <= {redundant_strap, seu_pin, pu_fault_pin, rcu_fault_pin};
			sync_r <= meta_r;
			sync_d_r <= sync_r[2:0];
		end
	end
	wire logic [2:0] pin_rise = sync_r[2:0] & ~sync_d_r;

	// Background ROM checksum, one word per step
	logic [15:0] step_r;
	logic [15:0] sum_r;
	logic [ROM_AW-1:0] rom_addr_r;
	logic rom_err_r;
	wire logic tick = (step_r == STEP_LAST);
	wire logic [15:0] sum_fin = sum_r + rom_data;
	wire logic rom_wrap = tick && (rom_addr_r == ROM_LAST);
	wire logic mem_fail = rom_wrap && (sum_fin != ROM_SUM_REF);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			step_r <= 16'h0000;
			sum_r <= 16'h0000;
			rom_addr_r <= '0;
			rom_err_r <= 1'b0;
		end else begin
			step_r <= tick ? 16'h0000 : step_r + 16'h0001;
			if (tick) begin
				rom_addr_r <= rom_addr_r + 1'b1;
				sum_r <= rom_wrap ? 16'h0000 : sum_fin;
			end
			rom_err_r <= rom_err_r | mem_fail;
		end
	end

	// Event pending flags, lowest index has priority
	erpg_ev_if evi ();
	logic [3:0] pend_r;
	logic req_r;
	logic [15:0] ev_id_r;
	logic [31:0] ev_obs_r;
	logic [31:0] ev_bb_r;
	logic [47:0] ev_time_r;
	wire logic [3:0] cause = {obs_corrected, obs_anomaly, pin_rise[1] | mem_fail, pin_rise[0]};
	wire logic can_issue = !evi.busy && !req_r && (pend_r != 4'h0);
	wire logic [3:0] gnt = pend_r & (~pend_r + 4'h1);
	wire logic [15:0] gnt_id = gnt[0] ? erpg_pkg::EV_RCU_FAULT :
		gnt[1] ? erpg_pkg::EV_PU_FAULT :
		gnt[2] ? erpg_pkg::EV_OBS_FAULT :
		erpg_pkg::EV_OBS_FIXED;
	// New cause wins over the clear by a grant
	wire logic [3:0] pend_nxt = cause | (pend_r & ~(can_issue ? gnt : 4'h0));
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pend_r <= 4'h0;
			req_r <= 1'b0;
			ev_id_r <= 16'h0000;
			ev_obs_r <= 32'h0000_0000;
			ev_bb_r <= 32'h0000_0000;
			ev_time_r <= 48'h0000_0000_0000;
		end else begin
			pend_r <= pend_nxt;
			req_r <= can_issue;
			if (can_issue) begin
				ev_id_r <= gnt_id;
				ev_obs_r <= obs_id;
				ev_bb_r <= bb_id;
				ev_time_r <= obs_time;
			end
		end
	end
	assign evi.req = req_r;
	assign evi.ev_id = ev_id_r;
	assign evi.obs_id = ev_obs_r;
	assign evi.bb_id = ev_bb_r;
	assign evi.ev_time = ev_time_r;

	erpg_ser u_ser (
		.core_clk(core_clk),
		.rst(rst),
		.ev(evi),
		.tx_ready(tx_ready),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_last(tx_last)
	);

	// Telecommand length and hazard screening
	logic [8:0] tc_cnt_r;
	logic [7:0] op_r;
	logic over_r;
	logic tc_accept_r;
	logic tc_reject_r;
	logic safe_r;
	wire logic [7:0] tc_op = tc_first ? tc_data : op_r;
	wire logic [8:0] tc_cnt_nxt = tc_first ? 9'h001 :
		(tc_cnt_r == erpg_pkg::TC_CNT_SAT) ? tc_cnt_r : tc_cnt_r + 9'h001;
	wire logic tc_over = (tc_cnt_nxt > erpg_pkg::TC_MAX_OCTETS) || (over_r && !tc_first);
	wire logic tc_done = tc_valid && tc_last;
	wire logic tc_hazard = tc_op[erpg_pkg::OP_HAZ_BIT] && safe_r;
	wire logic tc_bad = tc_over || tc_hazard;
	wire logic cmd_safe = tc_done && !tc_bad && (tc_op == erpg_pkg::OP_SAFE);
	wire logic cmd_resume = tc_done && !tc_bad && (tc_op == erpg_pkg::OP_RESUME);
	wire logic seu_safe = pin_rise[2] && !seu_safing_inhibit;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tc_cnt_r <= 9'h000;
			op_r <= 8'h00;
			over_r <= 1'b0;
			tc_accept_r <= 1'b0;
			tc_reject_r <= 1'b0;
			safe_r <= 1'b0;
		end else begin
			if (tc_valid) begin
				tc_cnt_r <= tc_cnt_nxt;
				op_r <= tc_op;
				over_r <= tc_over;
			end
			tc_accept_r <= tc_done && !tc_bad;
			tc_reject_r <= tc_done && tc_bad;
			safe_r <= cmd_safe || seu_safe || (safe_r && !cmd_resume);
		end
	end

	// Bus address caught from the strap once synchronised
	logic [1:0] cap_cnt_r;
	logic [4:0] rt_addr_r;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cap_cnt_r <= 2'h0;
			rt_addr_r <= erpg_pkg::RT_ADDR_PRIME;
		end else begin
			if (cap_cnt_r != 2'h3) begin
				cap_cnt_r <= cap_cnt_r + 2'h1;
			end
			if (cap_cnt_r == erpg_pkg::CAP_AT) begin
				rt_addr_r <= sync_r[3] ? erpg_pkg::RT_ADDR_REDUN : erpg_pkg::RT_ADDR_PRIME;
			end
		end
	end

	assign tc_accept = tc_accept_r;
	assign tc_reject = tc_reject_r;
	assign safe_mode = safe_r;
	assign rt_addr = rt_addr_r;
	assign rom_addr = rom_addr_r;
	assign rom_err = rom_err_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_rcu_event_id: assert property (can_issue && pend_r[0] |=> req_r && ev_id_r == 16'hC000)
		else $error("readout fault not reported as C000");
	a_pu_event_id: assert property (can_issue && pend_r[1:0] == 2'h2 |=> ev_id_r == 16'hC010)
		else $error("unit fault not reported as C010");
	a_obs_event_id: assert property (can_issue && pend_r[2:0] == 3'h4 |=> ev_id_r == 16'hC100)
		else $error("observation fault not reported as C100");
	a_fix_event_id: assert property (can_issue && pend_r == 4'h8 |=> ev_id_r == 16'hC110)
		else $error("observation fix not reported as C110");
	a_overlen_reject: assert property (tc_done && tc_over |=> tc_reject_r && !tc_accept_r)
		else $error("over-length telecommand accepted");
	a_safe_single: assert property (cmd_safe |=> safe_r ##1 (safe_r || $past(cmd_resume)))
		else $error("single safe command did not hold safe mode");
	a_addr_distinct: assert property (cap_cnt_r == 2'h2 |=> rt_addr_r == ($past(sync_r[3]) ? 5'h02 : 5'h01))
		else $error("bus address does not follow unit strap");
	a_hazard_reject: assert property (tc_done && safe_r && tc_op[7] |=> tc_reject_r)
		else $error("hazardous command accepted in safe mode");
	a_rom_fail_event: assert property (mem_fail && !pend_r[1] |=> pend_r[1] && rom_err_r)
		else $error("ROM checksum failure not raised");
	c_event_issued: cover property (can_issue ##1 req_r);
	c_safe_entry: cover property (!safe_r ##1 safe_r);
	c_tc_reject: cover property (tc_reject_r);
	c_rom_fail: cover property (mem_fail);
endmodule // erpg_top

// >>> verification/erpg_sink.sv
// Purpose: Spacecraft data system sink for event report words
// Assumes: A word is taken on tx_valid and tx_ready at the core_clk rise
// Notes: slow makes the sink stall every other cycle
module erpg_sink (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [15:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic tx_ready,
	output logic [15:0] pkt [16],
	output int n_pkt,
	output logic is_event
);
	timeunit 1ns;
	timeprecision 1ns;
	int idx = 0;
	initial begin
		tx_ready = 1'h0;
		n_pkt = 0;
		is_event = 1'h0;
	end
	always @(posedge core_clk) begin
		if (!rst && tx_valid && tx_ready) begin
			pkt[idx] = tx_data;
			idx = tx_last ? 0 : idx + 1;
			if (tx_last) begin
				is_event = (pkt[3][7:0] === erpg_pkg::SVC_TYPE);
				n_pkt++;
			end
		end
		tx_ready <= #1 slow ? ~tx_ready : !rst;
	end
endmodule // erpg_sink

// >>> verification/event_report_packet_gen_bench.sv
// Purpose: Self-checking bench of the event report packet generator
// Assumes: Inputs change 1 ns after the core_clk rise
// Notes: ROM scan shortened to four words
module event_report_packet_gen_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'h0, rst = 1'h1, rcu_fault_pin = 1'h0, pu_fault_pin = 1'h0, seu_pin = 1'h0;
	logic redundant_strap = 1'h0, obs_anomaly = 1'h0, obs_corrected = 1'h0, seu_safing_inhibit = 1'h0;
	logic tc_valid = 1'h0, tc_first = 1'h0, tc_last = 1'h0, slow = 1'h0, rom_bad = 1'h0;
	logic [7:0] tc_data = 8'h00;
	logic [31:0] obs_id = 32'h1234_5678, bb_id = 32'h9ABC_DEF0;
	logic [47:0] obs_time = 48'h0102_0304_0506;
	logic [15:0] rom_data = 16'h1000;
	logic [15:0] tx_data;
	logic [1:0] rom_addr;
	logic tx_ready, tx_valid, tx_last, tc_accept, tc_reject, safe_mode, rom_err, is_event;
	logic [4:0] rt_addr;
	logic [15:0] pkt [16];
	int n_pkt, fail_count = 0, checks = 0, seq = 0;

	initial forever #25 core_clk = ~core_clk;
	// ROM image sums to 16'h4006 unless corrupted
	always @(posedge core_clk) rom_data <= #1 16'h1000 + {14'h0, rom_addr} + (rom_bad ? 16'h0100 : 16'h0000);

	erpg_top #(.ROM_AW(2), .ROM_SUM_REF(16'h4006)) u_dut (.core_clk, .rst, .rcu_fault_pin, .pu_fault_pin,
		.seu_pin, .redundant_strap, .obs_anomaly, .obs_corrected, .seu_safing_inhibit, .obs_id, .bb_id,
		.obs_time, .tc_valid, .tc_first, .tc_last, .tc_data, .rom_data, .tx_ready, .tx_data, .tx_valid,
		.tx_last, .tc_accept, .tc_reject, .safe_mode, .rt_addr, .rom_addr, .rom_err);
	erpg_sink u_sink (.core_clk, .rst, .slow, .tx_data, .tx_valid, .tx_last, .tx_ready, .pkt, .n_pkt,
		.is_event);

	task automatic report_and_stop();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic expect_pkt(input logic [15:0] id);
		logic [15:0] w [16];
		logic [15:0] sum;
		int n0, i;
		n0 = n_pkt;
		for (i = 0; i < 400 && n_pkt == n0; i++) step(1);
		check(16'(n_pkt - n0), 16'h0001, "packet count");
		w = '{{erpg_pkg::HDR_FLAGS, erpg_pkg::APID}, {erpg_pkg::SEQ_FLAGS, 14'(seq)}, erpg_pkg::PKT_LEN,
			{erpg_pkg::DFH_FLAGS, erpg_pkg::SVC_TYPE}, {erpg_pkg::SVC_SUBTYPE, erpg_pkg::DFH_SPARE},
			obs_time[47:32], obs_time[31:16], obs_time[15:0], id, erpg_pkg::SID, obs_id[31:16],
			obs_id[15:0], bb_id[31:16], bb_id[15:0], 16'(seq), 16'h0000};
		sum = 16'h0000;
		for (i = 0; i < 15; i++) sum += w[i];
		w[15] = sum;
		for (i = 0; i < 16; i++) check(pkt[i], w[i], "packet word");
		check({15'h0, is_event}, 16'h0001, "report type");
		seq++;
	endtask
	task automatic send_tc(input logic [7:0] op, input int len, input logic acc);
		int i;
		// One command per call, idle cycle after it, time scale compressed
		for (i = 0; i < len; i++) begin
			tc_valid = 1'h1;
			tc_first = (i == 0);
			tc_last = (i == len - 1);
			tc_data = (i == 0) ? op : 8'(i);
			step(1);
		end
		tc_valid = 1'h0;
		tc_last = 1'h0;
		check({14'h0, tc_accept, tc_reject}, {14'h0, acc, ~acc}, "command answer");
		step(1);
	endtask

	task automatic t_strap();
		check({11'h0, rt_addr}, {11'h0, erpg_pkg::RT_ADDR_PRIME}, "prime address");
		redundant_strap = 1'h1;
		step(4);
		rst = 1'h1;
		step(4);
		rst = 1'h0;
		step(4);
		check({11'h0, rt_addr}, {11'h0, erpg_pkg::RT_ADDR_REDUN}, "redundant address");
	endtask
	task automatic t_faults();
		rcu_fault_pin = 1'h1;
		expect_pkt(erpg_pkg::EV_RCU_FAULT);
		slow = 1'h1;
		pu_fault_pin = 1'h1;
		expect_pkt(erpg_pkg::EV_PU_FAULT);
	endtask
	task automatic t_obs();
		obs_id = 32'hA5A5_0001;
		obs_anomaly = 1'h1;
		obs_corrected = 1'h1;
		step(1);
		obs_anomaly = 1'h0;
		obs_corrected = 1'h0;
		expect_pkt(erpg_pkg::EV_OBS_FAULT);
		expect_pkt(erpg_pkg::EV_OBS_FIXED);
		slow = 1'h0;
	endtask
	task automatic t_tc();
		send_tc(8'h01, 256, 1'h1);
		send_tc(8'h01, 257, 1'h0);
		send_tc(erpg_pkg::OP_SAFE, 1, 1'h1);
		check({15'h0, safe_mode}, 16'h0001, "safe entry");
		send_tc(8'h81, 1, 1'h0);
		send_tc(erpg_pkg::OP_RESUME, 1, 1'h1);
		check({15'h0, safe_mode}, 16'h0000, "safe exit");
		send_tc(8'h81, 2, 1'h1);
	endtask
	task automatic t_seu();
		seu_safing_inhibit = 1'h1;
		seu_pin = 1'h1;
		step(8);
		check({15'h0, safe_mode}, 16'h0000, "inhibited upset");
		seu_pin = 1'h0;
		seu_safing_inhibit = 1'h0;
		step(8);
		seu_pin = 1'h1;
		step(8);
		check({15'h0, safe_mode}, 16'h0001, "upset safing");
		seu_pin = 1'h0;
		send_tc(erpg_pkg::OP_RESUME, 1, 1'h1);
	endtask
	task automatic t_rom();
		int i;
		step(4500);
		check({15'h0, rom_err}, 16'h0000, "rom clean");
		rom_bad = 1'h1;
		for (i = 0; i < 9000 && rom_err !== 1'h1; i++) step(1);
		check({15'h0, rom_err}, 16'h0001, "rom fault");
		expect_pkt(erpg_pkg::EV_PU_FAULT);
	endtask

	initial begin
		repeat (30000) @(posedge core_clk);
		fail_count++;
		report_and_stop();
	end
	initial begin
		step(4);
		rst = 1'h0;
		step(4);
		t_strap();
		t_faults();
		t_obs();
		t_tc();
		t_seu();
		t_rom();
		report_and_stop();
	end
endmodule // event_report_packet_gen_bench
